/* File: rtl/ftsp_fifo.sv */
// small synchronous fifo holding posted writes
`timescale 1ns/1ns
`default_nettype none
module ftsp_fifo #(
    parameter int WIDTH = 46,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PTR_W:0] cnt_q, cnt_d;
    logic push, pop;

    // handshakes and honest flags
    assign in_ready_o = (cnt_q != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = store[rd_ptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer and count next values
    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_ptr_d = (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // pointer registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q <= cnt_d;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr_q] <= in_data_i;
        end
    end
endmodule // ftsp_fifo
`default_nettype wire

/* File: rtl/ftsp_pkg.sv */
// shared constants for the flow-through sram port
package ftsp_pkg;
    // geometry of the port
    localparam int FTSP_LANES = 4;
    localparam int FTSP_LANE_W = 8;
    localparam int FTSP_ADDR_W = 10;
    localparam int FTSP_BURST_W = 2;
    localparam int FTSP_POST_DEPTH = 8;
    // reset values
    localparam logic [FTSP_BURST_W-1:0] FTSP_OFF_RST = 2'h0;
    localparam logic [FTSP_LANES-1:0] FTSP_BE_RST = 4'h0;
    // operation held in the current bus cycle
    typedef enum logic [1:0] {
        FTSP_OP_IDLE,
        FTSP_OP_READ,
        FTSP_OP_WRITE
    } ftsp_op_t;
endpackage

/* File: rtl/ftsp_port.sv */
// host port and memory core of the flow-through burst sram
`timescale 1ns/1ns
`default_nettype none
module ftsp_port
    import ftsp_pkg::*;
#(
    parameter int ADDR_W = FTSP_ADDR_W,
    parameter int LANES = FTSP_LANES,
    parameter int LANE_W = FTSP_LANE_W,
    parameter int POST_DEPTH = FTSP_POST_DEPTH
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // synchronous control
    input wire logic clock_qualifier_n_i,
    input wire logic chip_select_first_n_i,
    input wire logic chip_select_second_hi_i,
    input wire logic chip_select_third_n_i,
    input wire logic write_enable_n_i,
    input wire logic advance_or_load_i,
    input wire logic [LANES-1:0] byte_lane_write_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    // asynchronous control and strap
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic burst_interleave_i,
    // data lines
    input wire logic [LANES*LANE_W-1:0] data_lines_i,
    output logic [LANES*LANE_W-1:0] data_lines_o,
    output logic data_lines_oe_o,
    // parity lanes
    input wire logic [LANES-1:0] parity_lane_lines_i,
    output logic [LANES-1:0] parity_lane_lines_o,
    output logic parity_lane_lines_oe_o,
    // posted-write queue and sleep status
    output logic post_ready_o,
    output logic asleep_o
);
    localparam int DEPTH = 2 ** ADDR_W;
    localparam int LW = LANE_W + 1;
    localparam int PW = ADDR_W + LANES + LANES * LW;

    ftsp_op_t op_q, op_d;
    logic [ADDR_W-1:0] base_q, base_d, cur_addr;
    logic [FTSP_BURST_W-1:0] off_q, off_d, low_bits;
    logic [LANES-1:0] be_q, be_d;
    logic emerge_q, emerge_d;
    logic sleeping, edge_ok, selected;
    logic post_valid, post_in_ready, head_valid, drain;
    logic [PW-1:0] post_word, head_word;
    logic [ADDR_W-1:0] head_addr;
    logic [LANES-1:0] head_be;
    logic [LANES*LW-1:0] head_data, wr_word, rd_word;

    // sleep acts at once, without waiting for a clock edge
    // the pin has a pull-down, so only a driven high means sleep
    // pull-down default
    assign sleeping = (sleep_request_i === 1'b1);
    assign asleep_o = sleeping;

    // an edge counts only with qualifier low and the part awake
    // clock qualification
    assign edge_ok = !clock_qualifier_n_i && !sleeping;

    // select decode from the three chip selects
    // select decode
    assign selected = !chip_select_first_n_i && chip_select_second_hi_i &&
                      !chip_select_third_n_i;

    // burst address from base and two-bit offset
    // burst order
    always_comb begin
        if (burst_interleave_i) begin
            low_bits = base_q[FTSP_BURST_W-1:0] ^ off_q;
        end else begin
            low_bits = base_q[FTSP_BURST_W-1:0] + off_q;
        end
        cur_addr = {base_q[ADDR_W-1:FTSP_BURST_W], low_bits};
    end

    // next command state at a recognized edge
    always_comb begin
        op_d = op_q;
        base_d = base_q;
        off_d = off_q;
        be_d = be_q;
        emerge_d = emerge_q;
        if (edge_ok) begin
            emerge_d = 1'b0;
            if (advance_or_load_i) begin
                // an advance while deselected stays deselected
                if (op_q != FTSP_OP_IDLE) begin
                    off_d = off_q + 1'b1;
                    be_d = ~byte_lane_write_n_i;
                end
            end else if (selected) begin
                op_d = write_enable_n_i ? FTSP_OP_READ : FTSP_OP_WRITE;
                base_d = addr_i;
                off_d = FTSP_OFF_RST;
                be_d = ~byte_lane_write_n_i;
                // leaving deselect masks the drivers for one clock
                emerge_d = (op_q == FTSP_OP_IDLE);
            end else begin
                // any select off at a load edge deselects
                op_d = FTSP_OP_IDLE;
                be_d = FTSP_BE_RST;
            end
        end
    end

    // command state registers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_q <= FTSP_OP_IDLE;
            base_q <= '0;
            off_q <= FTSP_OFF_RST;
            be_q <= FTSP_BE_RST;
            emerge_q <= 1'b0;
        end else begin
            op_q <= op_d;
            base_q <= base_d;
            off_q <= off_d;
            be_q <= be_d;
            emerge_q <= emerge_d;
        end
    end

    // write data phase: pins captured at the closing edge
    // data register capture
    assign post_valid = edge_ok && (op_q == FTSP_OP_WRITE) && (be_q != '0);
    assign post_ready_o = post_in_ready;

    // pack each lane as parity above its byte
    // parity with its lane
    for (genvar l = 0; l < LANES; l++) begin : g_pack
        assign wr_word[l*LW +: LW] = {parity_lane_lines_i[l],
                                      data_lines_i[l*LANE_W +: LANE_W]};
    end
    // the current address and strobes travel with the data
    assign post_word = {cur_addr, be_q, wr_word};

    // a full queue would drop a write; outside sleep it drains
    // every clock, so at most one entry is ever waiting
    // posted writes wait here until the core is free
    ftsp_fifo #(
        .WIDTH(PW),
        .DEPTH(POST_DEPTH)
    ) u_post (
        .clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(post_valid),
        .in_ready_o(post_in_ready),
        .in_data_i(post_word),
        .out_valid_o(head_valid),
        .out_ready_i(drain),
        .out_data_o(head_word)
    );

    // the core takes no writes while asleep
    // sleep stalls core
    assign drain = head_valid && !sleeping;
    assign head_addr = head_word[PW-1 -: ADDR_W];
    assign head_be = head_word[LANES*LW +: LANES];
    assign head_data = head_word[LANES*LW-1:0];

    // one memory per lane, written only under its strobe
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LW-1:0] mem [DEPTH];
        logic hit;
        always_ff @(posedge core_clk_i) begin
            if (drain && head_be[l]) begin
                mem[head_addr] <= head_data[l*LW +: LW];
            end
        end
        // at most one write waits outside sleep, so the head is enough
        // a write still queued for this address wins over the array
        assign hit = head_valid && head_be[l] && (head_addr == cur_addr);
        assign rd_word[l*LW +: LW] = hit ? head_data[l*LW +: LW] :
                                           mem[cur_addr];
        assign data_lines_o[l*LANE_W +: LANE_W] = rd_word[l*LW +: LANE_W];
        assign parity_lane_lines_o[l] = rd_word[l*LW + LANE_W];
    end

    // deselected, write data and emerging cycles all keep drivers off
    // drivers on only for a read cycle with output enable low
    // output enable gating
    assign data_lines_oe_o = !output_enable_n_i && !sleeping &&
                             (op_q == FTSP_OP_READ) && !emerge_q;
    assign parity_lane_lines_oe_o = data_lines_oe_o;
endmodule // ftsp_port
`default_nettype wire

/* File: tb/ftsp_ctrl_model.sv */
// controller side of the data bus: wire resolution and sleep pull-down
`timescale 1ns/1ns
`default_nettype none
module ftsp_ctrl_model (
    // clock and drivers
    input wire logic clk_i,
    input wire logic drv_en_i,
    input wire logic [35:0] drv_i,
    input wire logic dut_oe_i,
    input wire logic [35:0] dut_i,
    input wire logic sleep_req_i,
    // resolved lines
    output logic [35:0] bus_o,
    output logic sleep_o
);
    logic [35:0] idle_q = 36'h0;
    // released bus toggles so stale data never looks valid
    always @(negedge clk_i) idle_q <= ~idle_q;
    // contention resolves to unknown
    always_comb begin
        bus_o = idle_q;
        if (dut_oe_i && drv_en_i) bus_o = 'x;
        else if (dut_oe_i) bus_o = dut_i;
        else if (drv_en_i) bus_o = drv_i;
    end
    assign sleep_o = (sleep_req_i === 1'b1);
endmodule // ftsp_ctrl_model
`default_nettype wire

/* File: tb/ftsp_port_chk.sv */
// assertions on the sram port output control
`timescale 1ns/1ns
`default_nettype none
module ftsp_port_chk (
    // watched ports
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clock_qualifier_n_i,
    input wire logic chip_select_first_n_i,
    input wire logic chip_select_second_hi_i,
    input wire logic chip_select_third_n_i,
    input wire logic write_enable_n_i,
    input wire logic advance_or_load_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic data_lines_oe_o,
    input wire logic parity_lane_lines_oe_o,
    input wire logic asleep_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic ld;
    logic sel;
    assign ld = !clock_qualifier_n_i && !sleep_request_i && !advance_or_load_i;
    assign sel = !chip_select_first_n_i && chip_select_second_hi_i
        && !chip_select_third_n_i;
    sequence s_rd; ld && sel && write_enable_n_i; endsequence
    sequence s_wr; ld && sel && !write_enable_n_i; endsequence
    sequence s_ds; ld && !sel; endsequence
    a_oe_high_off: assert property (
        output_enable_n_i |-> !data_lines_oe_o)
        else $error("data driven with output enable high");
    a_parity_oe_same: assert property (
        parity_lane_lines_oe_o == data_lines_oe_o)
        else $error("parity enable differs from data enable");
    a_sleep_off: assert property (
        sleep_request_i |-> asleep_o && !data_lines_oe_o)
        else $error("driving or awake during sleep");
    a_write_data_off: assert property (s_wr |=> !data_lines_oe_o)
        else $error("driven in write data phase");
    a_desel_off: assert property (s_ds |=> !data_lines_oe_o)
        else $error("driven while deselected");
    a_emerge_off: assert property (s_ds ##1 s_rd |=> !data_lines_oe_o)
        else $error("driven in first cycle after deselect");
    a_read_on: assert property (s_rd ##1 s_rd ##1
        (!output_enable_n_i && !sleep_request_i) |-> data_lines_oe_o)
        else $error("read data not driven");
    a_masked_hold: assert property (
        clock_qualifier_n_i && !sleep_request_i |=>
        ($stable(output_enable_n_i) && !sleep_request_i) |->
        $stable(data_lines_oe_o))
        else $error("masked edge changed output enable");
endmodule // ftsp_port_chk
bind ftsp_port ftsp_port_chk i_chk (.*);
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the flow-through sram port
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ftsp_pkg::*;
    logic core_clk_i = 0, rst_i = 1, clock_qualifier_n_i = 1;
    logic chip_select_first_n_i = 1, chip_select_second_hi_i = 0;
    logic chip_select_third_n_i = 1, write_enable_n_i = 1;
    logic advance_or_load_i = 0, output_enable_n_i = 1, sleep_request_i;
    logic burst_interleave_i = 0, data_lines_oe_o, parity_lane_lines_oe_o;
    logic [3:0] byte_lane_write_n_i = 4'hf, parity_lane_lines_i;
    logic [3:0] parity_lane_lines_o, wbw;
    logic [9:0] addr_i = 10'h0, base, cur;
    logic [31:0] data_lines_i, data_lines_o, r;
    logic post_ready_o, asleep_o, drv_en = 0, sleep_req = 0, exp_oe = 0;
    logic emerg = 0;
    logic [35:0] bus, drv = 36'h0, wd;
    logic [1:0] off;
    logic [35:0] mem [int];
    ftsp_op_t op = FTSP_OP_IDLE;
    int seed = 28556, failures = 0, checks_done = 0;
    ftsp_port i_dut (.*);
    ftsp_ctrl_model i_ctrl (.clk_i(core_clk_i), .drv_en_i(drv_en),
        .drv_i(drv), .dut_oe_i(data_lines_oe_o),
        .dut_i({parity_lane_lines_o, data_lines_o}), .sleep_req_i(sleep_req),
        .bus_o(bus), .sleep_o(sleep_request_i));
    assign {parity_lane_lines_i, data_lines_i} = bus;
    always #25 core_clk_i = ~core_clk_i;
    // burst address from base and offset
    function automatic logic [9:0] addr_of(logic [9:0] b, logic [1:0] o);
        return {b[9:2], burst_interleave_i ? b[1:0] ^ o : b[1:0] + o};
    endfunction
    // lanes with low strobe take new data and parity
    function automatic logic [35:0] merge(logic [35:0] o, n, logic [3:0] bn);
        for (int l = 0; l < 4; l++) begin
            if (!bn[l]) begin
                o[8*l +: 8] = n[8*l +: 8];
                o[32+l] = n[32+l];
            end
        end
        return o;
    endfunction
    task automatic chk(input logic [35:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // check the cycle, drive the next one, model its edge
    task automatic step(input logic qn, s, wn, adv, input logic [9:0] a,
                        input logic [3:0] bw, input logic sl);
        logic [2:0] cs;
        @(negedge core_clk_i);
        chk(data_lines_oe_o, exp_oe);
        if (exp_oe)
            chk({parity_lane_lines_o, data_lines_o}, mem[cur]);
        chk({post_ready_o, asleep_o}, {1'b1, sleep_req === 1'b1});
        cs = s ? 3'h2 : 3'($random(seed));
        if (!s && cs == 3'h2) cs = 3'h6;
        {chip_select_first_n_i, chip_select_second_hi_i} = cs[2:1];
        chip_select_third_n_i = cs[0];
        clock_qualifier_n_i = qn;
        write_enable_n_i = wn;
        advance_or_load_i = adv;
        addr_i = a;
        byte_lane_write_n_i = bw;
        // sleep pin high when asked, otherwise low or left open
        sleep_req = sl ? 1'b1 : ($random(seed) & 1) ? 1'bz : 1'b0;
        output_enable_n_i = (($random(seed) & 3) == 0);
        drv_en = (op == FTSP_OP_WRITE);
        drv = wd;
        // masked or sleeping edges change nothing
        if (!qn && !sl) begin
            if (op == FTSP_OP_WRITE) mem[cur] = merge(mem[cur], wd, wbw);
            emerg = 0;
            if (!adv) begin
                emerg = (op == FTSP_OP_IDLE) && s;
                op = !s ? FTSP_OP_IDLE : wn ? FTSP_OP_READ : FTSP_OP_WRITE;
                base = a;
                off = 2'h0;
            end else if (op != FTSP_OP_IDLE) off++;
            cur = addr_of(base, off);
            wbw = bw;
            wd = 36'({$random(seed), $random(seed)});
        end
        exp_oe = op == FTSP_OP_READ && !output_enable_n_i && !emerg && !sl;
    endtask
    initial begin
        repeat (12) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 0;
        for (int m = 0; m < 2; m++) begin
            step(0, 0, 1, 0, 10'h0, 4'hf, 0);
            step(0, 0, 1, 0, 10'h0, 4'hf, 0);
            burst_interleave_i = m[0];
            for (int i = 0; i < 16; i++) step(0, 1, 0, 0, i[9:0], 4'h0, 0);
            for (int i = 0; i < 16; i++)
                step(0, 1, 1, i[1:0] != 0, i[9:0], 4'h0, 0);
            step(0, 1, 0, 0, 10'h3, 4'h5, 0);
            step(0, 1, 1, 0, 10'h3, 4'hf, 0);
            repeat (400) begin
                r = $random(seed);
                step(r[2:0] == 0, r[5:3] != 0, r[6], r[8:7] != 0,
                     {6'h0, r[12:9]}, r[16:13], r[22:17] == 0);
            end
            $display("test burst mode %0d done", m);
        end
        test_done;
    end
    initial begin
        repeat (30000) @(posedge core_clk_i);
        failures++;
        test_done;
    end
endmodule // tb
`default_nettype wire
